//--- bench/pli_far_model.sv
`timescale 1ns/1ps

module pli_far_model (
  // Clock
  ref_clk,
  // Raw source events toward the block
  parity_evt,
  bm1_evt,
  bm2_evt,
  // Clearing reads done by the local processor
  parity_stat_rd,
  attn_port_rd,
  bm1_stat_rd,
  bm2_stat_rd
);
  input wire logic ref_clk;
  output logic parity_evt;
  output logic bm1_evt;
  output logic bm2_evt;
  output logic parity_stat_rd;
  output logic attn_port_rd;
  output logic bm1_stat_rd;
  output logic bm2_stat_rd;

  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    {parity_evt, bm1_evt, bm2_evt} = 3'h0;
    {parity_stat_rd, attn_port_rd, bm1_stat_rd, bm2_stat_rd} = 4'h0;
  end

  // ----------------------------------------
  // Event pulses, order {parity, bm1, bm2}
  // ----------------------------------------
  task automatic raise(input logic [2:0] m);
    @(posedge ref_clk);
    {parity_evt, bm1_evt, bm2_evt} <= m;
    @(posedge ref_clk);
    {parity_evt, bm1_evt, bm2_evt} <= 3'h0;
  endtask

  // ----------------------------------------
  // Clearing reads, order {parity, attn, bm1, bm2}
  // ----------------------------------------
  // A slow processor waits before servicing the lines
  task automatic clear_read(input logic [3:0] m, input int slow);
    repeat (slow) @(posedge ref_clk);
    @(posedge ref_clk);
    {parity_stat_rd, attn_port_rd, bm1_stat_rd, bm2_stat_rd} <= m;
    @(posedge ref_clk);
    {parity_stat_rd, attn_port_rd, bm1_stat_rd, bm2_stat_rd} <= 4'h0;
  endtask
endmodule

//--- bench/test_pci_to_local_irq_encoder.sv
`timescale 1ns/1ps
`include "pli_regs.svh"

module test_pci_to_local_irq_encoder;
  logic ref_clk, rst_n, cmd_reset, pci_attn_wr, pci_nmi_wr, lb_sel, lb_wr;
  logic cmd_busy_set, lb_ack, general_req, eot_req;
  logic parity_evt, bm1_evt, bm2_evt, parity_stat_rd, attn_port_rd, bm1_stat_rd, bm2_stat_rd;
  logic [3:0] int_code;
  logic [7:0] pci_attn_data, pci_nmi_rdata;
  logic [31:0] lb_addr, lb_wdata, lb_rdata, rd;
  int fail_count = 0;
  int n_tests = 0;

  pli_irq_encoder u_pli_irq_encoder (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_reset(cmd_reset),
    .pci_attn_wr(pci_attn_wr), .pci_attn_data(pci_attn_data), .pci_nmi_wr(pci_nmi_wr),
    .pci_nmi_rdata(pci_nmi_rdata), .cmd_busy_set(cmd_busy_set), .lb_sel(lb_sel),
    .lb_wr(lb_wr), .lb_addr(lb_addr), .lb_wdata(lb_wdata), .lb_rdata(lb_rdata),
    .lb_ack(lb_ack), .parity_evt(parity_evt), .bm1_evt(bm1_evt), .bm2_evt(bm2_evt),
    .parity_stat_rd(parity_stat_rd), .attn_port_rd(attn_port_rd),
    .bm1_stat_rd(bm1_stat_rd), .bm2_stat_rd(bm2_stat_rd), .int_code(int_code),
    .general_req(general_req), .eot_req(eot_req));

  pli_far_model u_pli_far_model (.ref_clk(ref_clk), .parity_evt(parity_evt),
    .bm1_evt(bm1_evt), .bm2_evt(bm2_evt), .parity_stat_rd(parity_stat_rd),
    .attn_port_rd(attn_port_rd), .bm1_stat_rd(bm1_stat_rd), .bm2_stat_rd(bm2_stat_rd));

  // ----------------------------------------
  // Clock, watchdog, verdict
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // The whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end

  task give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task lb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    lb_sel <= 1'b1;
    lb_wr <= w;
    lb_addr <= a;
    lb_wdata <= d;
    @(posedge ref_clk);
    lb_sel <= 1'b0;
    #1;
    check("lb_ack", {31'h0, lb_ack}, 32'h1);
    rd = lb_rdata;
  endtask

  task rd_chk(input string what, input logic [31:0] a, input logic [31:0] e);
    lb(1'b0, a, 32'h0);
    check(what, rd, e);
  endtask

  task pci(input logic nmi, input logic [7:0] d);
    @(posedge ref_clk);
    if (nmi) begin
      pci_nmi_wr <= 1'b1;
    end else begin
      pci_attn_wr <= 1'b1;
      pci_attn_data <= d;
    end
    @(posedge ref_clk);
    pci_nmi_wr <= 1'b0;
    pci_attn_wr <= 1'b0;
    #1;
  endtask

  // Bounded poll: presentation passes through a short gap state
  task wait_code(input logic [3:0] e);
    int i;
    // Step off the edge that may launch a new code
    #1;
    for (i = 0; i < 8 && int_code !== e; i++) begin
      @(posedge ref_clk);
      #1;
    end
    check("int_code", {28'h0, int_code}, {28'h0, e});
  endtask

  always @(negedge ref_clk) begin
    if (rst_n === 1'b1 && int_code inside {[4'h7:4'hE]}) begin
      check("int_code reserved", {28'h0, int_code}, 32'hF);
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {rst_n, cmd_reset, pci_attn_wr, pci_nmi_wr, lb_sel, lb_wr} = 6'h00;
    {pci_attn_data, lb_addr, lb_wdata} = 72'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_code(4'hF);
    rd_chk("reset status", `PLI_RST_ADDR, 32'h0);
    rd_chk("nmi reg", `PLI_NMI_ADDR, 32'h0);
    rd_chk("unmapped", 32'h1FFA0030, 32'h0);
    lb(1'b1, `PLI_FLAG_ADDR, 32'hFFFF);
    rd_chk("flags", `PLI_FLAG_ADDR, 32'h0);
    pci(1'b0, 8'hDA);
    check("busy D", {31'h0, cmd_busy_set}, 32'h0);
    rd_chk("flags", `PLI_FLAG_ADDR, 32'h0400);
    check("eot_req", {31'h0, eot_req}, 32'h1);
    check("general_req", {31'h0, general_req}, 32'h0);
    wait_code(4'h3);
    pci(1'b0, 8'hD3);
    check("general_req", {31'h0, general_req}, 32'h1);
    lb(1'b1, `PLI_FLAG_ADDR, 32'hFFFF);
    wait_code(4'hF);
    wait_code(4'h3);
    rd_chk("flags", `PLI_FLAG_ADDR, 32'h0408);
    lb(1'b1, `PLI_FLAG_ADDR, 32'hFBFF);
    check("eot_req", {31'h0, eot_req}, 32'h0);
    wait_code(4'hF);
    wait_code(4'h4);
    lb(1'b1, `PLI_FLAG_ADDR, 32'h0);
    wait_code(4'hF);
    u_pli_far_model.raise(3'b111);
    wait_code(4'h1);
    repeat (5) @(posedge ref_clk);
    #1;
    check("held", {28'h0, int_code}, 32'h1);
    pci(1'b1, 8'h00);
    check("nmi code", {28'h0, int_code}, 32'h0);
    check("pci nmi", {24'h0, pci_nmi_rdata}, 32'h1);
    lb(1'b1, `PLI_NMI_ADDR, 32'h0);
    rd_chk("nmi reg", `PLI_NMI_ADDR, 32'h1);
    wait_code(4'h1);
    rd_chk("nmi reg", `PLI_NMI_ADDR, 32'h0);
    check("pci nmi", {24'h0, pci_nmi_rdata}, 32'h0);
    u_pli_far_model.clear_read(4'b1000, 3);
    wait_code(4'hF);
    wait_code(4'h5);
    u_pli_far_model.clear_read(4'b0001, 0);
    wait_code(4'hF);
    wait_code(4'h6);
    u_pli_far_model.clear_read(4'b0010, 1);
    wait_code(4'hF);
    pci(1'b0, 8'h31);
    check("busy", {31'h0, cmd_busy_set}, 32'h1);
    wait_code(4'h2);
    u_pli_far_model.clear_read(4'b0100, 0);
    wait_code(4'hF);
    pci(1'b0, 8'hDA);
    pci(1'b1, 8'h00);
    @(posedge ref_clk);
    cmd_reset <= 1'b1;
    @(posedge ref_clk);
    cmd_reset <= 1'b0;
    wait_code(4'hF);
    rd_chk("reset status", `PLI_RST_ADDR, 32'h1);
    rd_chk("nmi reg", `PLI_NMI_ADDR, 32'h0);
    rd_chk("flags", `PLI_FLAG_ADDR, 32'h0);
    give_verdict();
  end
endmodule

//--- logic/pli_irq_encoder.sv
`timescale 1ns/1ps
`include "pli_regs.svh"

// What this block does
// - Attention code D write sets source flag at the device-number index.
// - Source flags read and written directly only from the local bus.
// - Only PCI attention writes can set source flags.
// - Local write clears flags written 0, keeps flags written 1.
// - General request is OR of flags 7-0; end-of-transfer OR of 15-8.
// - Reset status bit 0 is 1 after command reset, 0 after hard reset.
// - Any PCI NMI write sets NMI status and presents code 0000.
// - Local read of NMI register returns status and clears it.
// - Exactly seven sources are driven onto four encoded lines.
// - Codes NMI 0 through channel 1 at 6; 7 to E never driven.
// - Lines sit at all ones with nothing presented.
// - Presented code holds until its clearing action; others stay pending.
// - After a clear, the highest-priority pending source comes next.
// - Among simultaneous sources the lowest code is presented first.
// - NMI bypasses the hold ordering and shows at once.
// - NMI and parity sources clear on their status register read.
// - Attention source clears on an attention port read.
// - Flag write clears general or end-of-transfer; reasserts while flags remain.
// - Channel sources clear on their channel status register read.
// - NMI register is 8-bit read/write on PCI, 32-bit read-only locally.
// - Attention bits 7-4 are the code, bits 3-0 the device number.
// - Attention code D writes do not set the command busy flag.

module pli_irq_encoder (
  // Clock and resets
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_reset,
  // PCI side writes
  input wire logic pci_attn_wr,
  input wire logic [7:0] pci_attn_data,
  input wire logic pci_nmi_wr,
  output logic [7:0] pci_nmi_rdata,
  output logic cmd_busy_set,
  // Local bus register port
  input wire logic lb_sel,
  input wire logic lb_wr,
  input wire logic [31:0] lb_addr,
  input wire logic [31:0] lb_wdata,
  output logic [31:0] lb_rdata,
  output logic lb_ack,
  // Raw source events
  input wire logic parity_evt,
  input wire logic bm1_evt,
  input wire logic bm2_evt,
  // Clearing actions outside this block
  input wire logic parity_stat_rd,
  input wire logic attn_port_rd,
  input wire logic bm1_stat_rd,
  input wire logic bm2_stat_rd,
  // Interrupt outputs
  output logic [3:0] int_code,
  output logic general_req,
  output logic eot_req
);

  pli_pkg::pli_top_state_t s;
  pli_pkg::pli_top_state_t next_s;
  pli_pick_if pick_if ();

  logic [3:0] attn_code;
  logic [3:0] attn_dev;
  logic attn_flag;
  logic attn_other;
  logic rd_nmi;
  logic rd_flag;
  logic rd_rst;
  logic wr_flag;
  logic [15:0] flags;
  logic [6:0] set_v;
  logic [6:0] clr_v;
  logic [6:0] lvl_v;
  logic [31:0] rd_word;

  // ----------------------------------------
  // Attention decode
  // ----------------------------------------
  assign attn_code = pci_attn_data[`PLI_ATTN_CODE_HI:`PLI_ATTN_CODE_LO];
  assign attn_dev = pci_attn_data[`PLI_ATTN_DEV_HI:`PLI_ATTN_DEV_LO];
  assign attn_flag = pci_attn_wr && (attn_code == `PLI_ATTN_FLAG_CODE);
  // Other codes go to the command logic and raise the attention source
  assign attn_other = pci_attn_wr && (attn_code != `PLI_ATTN_FLAG_CODE);

  // ----------------------------------------
  // Local bus decode
  // ----------------------------------------
  // Full-word compare keeps aliases of the flag register off the bus
  assign rd_nmi = lb_sel && !lb_wr && (lb_addr == `PLI_NMI_ADDR);
  assign rd_flag = lb_sel && !lb_wr && (lb_addr == `PLI_FLAG_ADDR);
  assign rd_rst = lb_sel && !lb_wr && (lb_addr == `PLI_RST_ADDR);
  // The NMI word is read-only here, so a write to it falls through
  assign wr_flag = lb_sel && lb_wr && (lb_addr == `PLI_FLAG_ADDR);

  always_comb begin
    rd_word = `PLI_WORD_RST;
    if (rd_nmi) begin
      rd_word = {31'h00000000, s.pend[`PLI_SRC_NMI]};
    end else if (rd_flag) begin
      rd_word = {16'h0000, flags};
    end else if (rd_rst) begin
      rd_word = {31'h00000000, s.rst_stat};
    end
  end

  // ----------------------------------------
  // Source flags
  // ----------------------------------------
  pli_src_flags u_pli_src_flags (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cmd_reset(cmd_reset),
    .set_strobe(attn_flag),
    .set_index(attn_dev),
    .clear_strobe(wr_flag),
    .clear_mask(lb_wdata[15:0]),
    .flags(flags),
    .general(general_req),
    .eot(eot_req)
  );

  // ----------------------------------------
  // Per-source set and clear
  // ----------------------------------------
  // Level sources follow the flag ORs; their clear only ends the showing
  assign lvl_v = {1'b0, 1'b0, general_req, eot_req, 1'b0, 1'b0, 1'b0};

  always_comb begin
    set_v = 7'h00;
    set_v[`PLI_SRC_NMI] = pci_nmi_wr;
    set_v[`PLI_SRC_PAR] = parity_evt;
    set_v[`PLI_SRC_ATTN] = attn_other;
    set_v[`PLI_SRC_EOT] = eot_req;
    set_v[`PLI_SRC_GEN] = general_req;
    set_v[`PLI_SRC_BM2] = bm2_evt;
    set_v[`PLI_SRC_BM1] = bm1_evt;
    clr_v = 7'h00;
    clr_v[`PLI_SRC_NMI] = rd_nmi;
    clr_v[`PLI_SRC_PAR] = parity_stat_rd;
    clr_v[`PLI_SRC_ATTN] = attn_port_rd;
    clr_v[`PLI_SRC_EOT] = wr_flag;
    clr_v[`PLI_SRC_GEN] = wr_flag;
    clr_v[`PLI_SRC_BM2] = bm2_stat_rd;
    clr_v[`PLI_SRC_BM1] = bm1_stat_rd;
  end

  assign pick_if.pending = s.pend;

  pli_prio_pick u_pli_prio_pick (
    .pick(pick_if.picker)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.busy_set = attn_other;
    next_s.ack = lb_sel;
    next_s.rdata = rd_word;
    for (int i = 0; i < `PLI_NUM_SRC; i++) begin
      if (lvl_v[i]) begin
        next_s.pend[i] = 1'b1;
      end else if (i == `PLI_SRC_EOT || i == `PLI_SRC_GEN) begin
        next_s.pend[i] = 1'b0;
      end else begin
        // A set in the same cycle as the clear is kept
        next_s.pend[i] = set_v[i] | (s.pend[i] & ~clr_v[i]);
      end
    end
    case (s.st)
      pli_pkg::PLI_IDLE: begin
        if (pick_if.valid) begin
          next_s.cur = pick_if.index;
          next_s.st = pli_pkg::PLI_SHOW;
        end
      end
      pli_pkg::PLI_SHOW: begin
        if (clr_v[s.cur]) begin
          next_s.st = pli_pkg::PLI_GAP;
        end
      end
      pli_pkg::PLI_GAP: begin
        // The gap cycle and the idle cycle after it put all ones on the lines for two cycles after the cleared code
        next_s.st = pli_pkg::PLI_IDLE;
      end
      default: begin
        next_s.st = pli_pkg::PLI_IDLE;
      end
    endcase
    if (cmd_reset) begin
      next_s.pend = `PLI_PEND_RST;
      next_s.st = pli_pkg::PLI_IDLE;
      next_s.cur = 3'h0;
      next_s.rst_stat = 1'b1;
      next_s.busy_set = 1'b0;
    end
    // NMI overrides whatever is held; the held code returns afterwards
    if (next_s.pend[`PLI_SRC_NMI]) begin
      next_s.int_code = `PLI_CODE_NMI;
    end else if (next_s.st == pli_pkg::PLI_SHOW) begin
      next_s.int_code = {1'b0, next_s.cur};
    end else begin
      next_s.int_code = `PLI_CODE_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s.st <= pli_pkg::PLI_IDLE;
      s.cur <= 3'h0;
      s.pend <= `PLI_PEND_RST;
      s.rst_stat <= 1'b0;
      s.int_code <= `PLI_CODE_IDLE;
      s.rdata <= `PLI_WORD_RST;
      s.ack <= 1'b0;
      s.busy_set <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign int_code = s.int_code;
  assign lb_rdata = s.rdata;
  assign lb_ack = s.ack;
  assign cmd_busy_set = s.busy_set;
  assign pci_nmi_rdata = {7'h00, s.pend[`PLI_SRC_NMI]};

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_nmi_now;
    @(posedge ref_clk) disable iff (!rst_n)
      (pci_nmi_wr && !cmd_reset) |=> (int_code == 4'h0) && pci_nmi_rdata[0];
  endproperty
  a_nmi_now: assert property (p_nmi_now) else $error("NMI not shown at once");

  property p_nmi_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd_nmi && !pci_nmi_wr && !cmd_reset) |=>
        !pci_nmi_rdata[0] && (lb_rdata[0] == $past(pci_nmi_rdata[0]));
  endproperty
  a_nmi_read: assert property (p_nmi_read) else $error("NMI read did not clear");

  property p_cmd_rst_stat;
    @(posedge ref_clk) disable iff (!rst_n)
      cmd_reset ##[1:4] rd_rst |=> lb_rdata == 32'h00000001;
  endproperty
  a_cmd_rst_stat: assert property (p_cmd_rst_stat) else $error("reset status wrong");

  property p_gen_or;
    @(posedge ref_clk) disable iff (!rst_n)
      (attn_flag && !attn_dev[3] && !cmd_reset) |=> general_req && !cmd_busy_set;
  endproperty
  a_gen_or: assert property (p_gen_or) else $error("general request missing");

  property p_no_busy_d;
    @(posedge ref_clk) disable iff (!rst_n)
      attn_flag |=> !cmd_busy_set;
  endproperty
  a_no_busy_d: assert property (p_no_busy_d) else $error("busy set by code D");

  property p_code_legal;
    @(posedge ref_clk) disable iff (!rst_n)
      (int_code <= 4'h6) || (int_code == 4'hF);
  endproperty
  a_code_legal: assert property (p_code_legal) else $error("reserved code driven");

  property p_idle_ones;
    @(posedge ref_clk) disable iff (!rst_n)
      (s.st != pli_pkg::PLI_SHOW && !s.pend[`PLI_SRC_NMI]) |-> int_code == 4'hF;
  endproperty
  a_idle_ones: assert property (p_idle_ones) else $error("lines not idle");

  property p_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (s.st == pli_pkg::PLI_SHOW && !clr_v[s.cur] && !cmd_reset) |=>
        (s.st == pli_pkg::PLI_SHOW) && $stable(s.cur);
  endproperty
  a_hold: assert property (p_hold) else $error("code dropped before clear");

  property p_next_pick;
    @(posedge ref_clk) disable iff (!rst_n)
      (s.st == pli_pkg::PLI_IDLE && pick_if.valid && !cmd_reset) |=>
        (s.cur == $past(pick_if.index)) && (int_code == {1'b0, s.cur} || s.pend[0]);
  endproperty
  a_next_pick: assert property (p_next_pick) else $error("wrong source picked");

  property p_clear_ends;
    @(posedge ref_clk) disable iff (!rst_n)
      (s.st == pli_pkg::PLI_SHOW && clr_v[s.cur] && !cmd_reset) |=>
        (s.st == pli_pkg::PLI_GAP) ##1 (s.st == pli_pkg::PLI_IDLE);
  endproperty
  a_clear_ends: assert property (p_clear_ends) else $error("no clear");

  property p_latch_kept;
    @(posedge ref_clk) disable iff (!rst_n)
      (bm1_evt && !cmd_reset) |=> s.pend[`PLI_SRC_BM1];
  endproperty
  a_latch_kept: assert property (p_latch_kept) else $error("pending latch lost");

endmodule

//--- logic/pli_pick_if.sv
`timescale 1ns/1ps

interface pli_pick_if;
  logic [6:0] pending;
  logic [2:0] index;
  logic valid;

  modport picker (input pending, output index, output valid);
  modport user (output pending, input index, input valid);
endinterface

//--- logic/pli_pkg.sv
package pli_pkg;

  // Gray steps idle -> show -> gap; gap -> idle flips both bits
  typedef enum logic [1:0] {
    PLI_IDLE = 2'b00,
    PLI_SHOW = 2'b01,
    PLI_GAP = 2'b11
  } pli_state_t;

  typedef struct packed {
    pli_state_t st;
    logic [2:0] cur;
    logic [6:0] pend;
    logic rst_stat;
    logic [3:0] int_code;
    logic [31:0] rdata;
    logic ack;
    logic busy_set;
  } pli_top_state_t;

  typedef struct packed {
    logic [15:0] flags;
  } pli_flag_state_t;

endpackage

//--- logic/pli_prio_pick.sv
`timescale 1ns/1ps

module pli_prio_pick (
  // Pending sources in, winner out
  pli_pick_if.picker pick
);

  // Lowest index wins; index equals the line code
  function automatic logic [2:0] pli_lowest(input logic [6:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (v[i]) begin
        idx = i[2:0];
      end
    end
    return idx;
  endfunction

  assign pick.index = pli_lowest(pick.pending);
  assign pick.valid = |pick.pending;

endmodule

//--- logic/pli_regs.svh
`ifndef PLI_REGS_SVH
`define PLI_REGS_SVH

// ----------------------------------------
// Local bus register addresses
// ----------------------------------------
`define PLI_NMI_ADDR 32'h1FFA001C
`define PLI_FLAG_ADDR 32'h1FFA0020
`define PLI_RST_ADDR 32'h1FFA0024

// ----------------------------------------
// Attention port fields and codes
// ----------------------------------------
`define PLI_ATTN_CODE_HI 7
`define PLI_ATTN_CODE_LO 4
`define PLI_ATTN_DEV_HI 3
`define PLI_ATTN_DEV_LO 0
`define PLI_ATTN_FLAG_CODE 4'hD

// ----------------------------------------
// Source indices, equal to their line codes
// ----------------------------------------
`define PLI_NUM_SRC 7
`define PLI_SRC_NMI 0
`define PLI_SRC_PAR 1
`define PLI_SRC_ATTN 2
`define PLI_SRC_EOT 3
`define PLI_SRC_GEN 4
`define PLI_SRC_BM2 5
`define PLI_SRC_BM1 6
`define PLI_CODE_NMI 4'h0
`define PLI_CODE_IDLE 4'hF

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PLI_FLAG_RST 16'h0000
`define PLI_PEND_RST 7'h00
`define PLI_WORD_RST 32'h00000000

`endif

//--- logic/pli_src_flags.sv
`timescale 1ns/1ps
`include "pli_regs.svh"

module pli_src_flags (
  // Clock and resets
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_reset,
  // Set from attention writes
  input wire logic set_strobe,
  input wire logic [3:0] set_index,
  // Clear from local bus writes
  input wire logic clear_strobe,
  input wire logic [15:0] clear_mask,
  // State
  output logic [15:0] flags,
  output logic general,
  output logic eot
);

  pli_pkg::pli_flag_state_t s;
  pli_pkg::pli_flag_state_t next_s;
  logic [15:0] set_bits;
  logic [15:0] keep_bits;

  // ----------------------------------------
  // Flag update
  // ----------------------------------------
  always_comb begin
    set_bits = set_strobe ? (16'h0001 << set_index) : 16'h0000;
    keep_bits = clear_strobe ? clear_mask : 16'hFFFF;
    next_s.flags = (s.flags & keep_bits) | set_bits;
    if (cmd_reset) begin
      next_s.flags = `PLI_FLAG_RST;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s.flags <= `PLI_FLAG_RST;
    end else begin
      s <= next_s;
    end
  end

  assign flags = s.flags;
  assign general = |s.flags[7:0];
  assign eot = |s.flags[15:8];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_attn_sets;
    @(posedge ref_clk) disable iff (!rst_n)
      (set_strobe && !cmd_reset) |=> flags[$past(set_index)];
  endproperty
  a_attn_sets: assert property (p_attn_sets) else $error("flag not set by attention");

  property p_zero_clears;
    @(posedge ref_clk) disable iff (!rst_n)
      (clear_strobe && !set_strobe && !cmd_reset) |=>
        flags == ($past(flags) & $past(clear_mask));
  endproperty
  a_zero_clears: assert property (p_zero_clears) else $error("flag clear wrong");

  property p_no_local_set;
    @(posedge ref_clk) disable iff (!rst_n)
      !set_strobe |=> (flags & ~$past(flags)) == 16'h0000;
  endproperty
  a_no_local_set: assert property (p_no_local_set) else $error("flag set locally");

endmodule
